// ---- logic/bhw_window.sv ----
// banked host i/o register window with serial memory fetch
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - only sixteen byte locations, banks overlay them
// - word 0xE-0xF selects bank, in every bank
// - byte lane enables give 8/16/32-bit accesses
// - one bank map for every bus width
// - 32-bit variant takes whole words in one access
// - window serves config, status and packet data
// - strap set: fetch seven words after reset
// - config bit 0 picks 16 or 8 bit
`include "bhw_defs.svh"

module bhw_window
	import bhw_pkg::*;
(
	input wire logic CLK, // core clock, 100 MHz
	input wire logic NRST, // asynchronous reset, active low
	input wire logic [3:0] HOST_ADDR, // host byte address in the window
	input wire logic [3:0] BYTE_LANE_ENABLES_N, // byte lane enables, active low
	input wire logic HOST_RD_N, // host read strobe, active low
	input wire logic HOST_WR_N, // host write strobe, active low
	input wire logic [31:0] HOST_DATA_IN, // data pins, host to device
	output logic [31:0] HOST_DATA_OUT, // data pins, device to host
	output logic HOST_DATA_OE, // high while device drives data pins
	input wire logic BUS_IS_32BIT, // strap: 32-bit bus variant
	input wire logic SERIAL_MEMORY_PRESENT_STRAP, // strap: serial memory fitted
	output logic EE_CS, // serial memory chip select
	output logic EE_SK, // serial memory shift clock
	output logic EE_DI, // serial memory data to memory
	input wire logic EE_DO, // serial memory data from memory
	output logic EXT_RD, // read pulse to upper-bank logic
	output logic EXT_WR, // write pulse to upper-bank logic
	output logic [15:0] EXT_BANK, // bank of the forwarded access
	output logic [1:0] EXT_WORD, // word offset of the forwarded access
	output logic [3:0] EXT_LANES, // active byte lanes, active high
	output logic [31:0] EXT_WDATA, // lane-aligned write data
	input wire logic [31:0] EXT_RDATA, // lane-aligned read data, same cycle as EXT_RD
	output logic HOST_BUS_WIDTH_SELECT, // 1: 16-bit host bus, 0: 8-bit
	output logic [15:0] LOADED_CONFIGURATION_WORD, // configuration word in use
	output logic [15:0] CHIP_SOFT_RESET, // soft reset control word
	output logic LOAD_DONE // serial memory fetch finished or skipped
);

	// ==========================================
	// state
	bhw_state_t r_reg; // registered state
	bhw_state_t r_next; // next state

	logic rd_edge; // synchronised read strobe just fell
	logic wr_edge; // synchronised write strobe just fell
	logic [1:0] word_base; // word of the access inside the window
	logic [3:0] lane_en; // active byte lanes
	logic [31:0] lane_data; // write data placed on the lanes
	logic [7:0] rbyte [16]; // read view of the active bank
	logic [15:0] we; // byte write enables per offset
	logic [7:0] wb [16]; // byte write data per offset
	logic [31:0] rword; // lane-aligned read word
	logic ext_sel; // active bank lies above the local banks
	logic [8:0] cmd; // read command shifted to memory

	// ==========================================
	// byte-wise update of a 16-bit register at an even offset
	function automatic logic [15:0] upd(input logic [15:0] old, input logic [3:0] o,
		input logic [15:0] en, input logic [7:0] d [16]);
		logic [15:0] v;
		v = old;
		if (en[o]) begin
			v[7:0] = d[o];
		end
		if (en[o + 4'h1]) begin
			v[15:8] = d[o + 4'h1];
		end
		return v;
	endfunction

	// ==========================================
	// lane steering
	// maps each access onto one word of the window and its byte lanes
	always_comb begin
		if (r_reg.b32_s2) begin
			// whole words in one access, lanes straight from the enables
			word_base = r_reg.addr_s2[3:2];
			lane_en = ~r_reg.be_s2;
			lane_data = r_reg.din_s2;
		end else if (HOST_BUS_WIDTH_SELECT) begin
			// 16-bit bus: half word chosen by address bit 1
			word_base = r_reg.addr_s2[3:2];
			lane_en = r_reg.addr_s2[1] ? {~r_reg.be_s2[1:0], 2'b00} :
				{2'b00, ~r_reg.be_s2[1:0]};
			lane_data = {r_reg.din_s2[15:0], r_reg.din_s2[15:0]};
		end else begin
			// 8-bit bus: single byte at the full address
			word_base = r_reg.addr_s2[3:2];
			lane_en = 4'h1 << r_reg.addr_s2[1:0];
			lane_data = {4{r_reg.din_s2[7:0]}};
		end
	end

	// ==========================================
	// read view and write enables of the window
	// the same bank map serves every bus width
	always_comb begin
		ext_sel = r_reg.bank_sel >= `BHW_BANK_EXT_FIRST;
		for (int i = 0; i < 16; i++) begin
			rbyte[i] = 8'h00; // reserved reads as zero
			we[i] = 1'b0;
			wb[i] = 8'h00;
		end
		// local banks, each register a little-endian byte pair
		unique case (r_reg.bank_sel)
			`BHW_BANK0: begin
				{rbyte[1], rbyte[0]} = r_reg.base_addr;
				{rbyte[5], rbyte[4]} = r_reg.wmark;
				{rbyte[7], rbyte[6]} = r_reg.fault;
				{rbyte[9], rbyte[8]} = r_reg.burst;
			end
			`BHW_BANK2: begin
				{rbyte[1], rbyte[0]} = r_reg.mac_lo;
				{rbyte[3], rbyte[2]} = r_reg.mac_mid;
				{rbyte[5], rbyte[4]} = r_reg.mac_hi;
			end
			`BHW_BANK3: begin
				{rbyte[1], rbyte[0]} = r_reg.bus_ctl;
				{rbyte[5], rbyte[4]} = r_reg.bist;
				{rbyte[7], rbyte[6]} = r_reg.soft_rst;
				{rbyte[9], rbyte[8]} = r_reg.bus_cfg;
			end
			default: begin
				// bank 1, banks 4 to 15 and upper banks hold nothing here
			end
		endcase
		// bank selector is the same word in every bank
		{rbyte[15], rbyte[14]} = r_reg.bank_sel;
		// only the sixteen decoded bytes can be written
		for (int i = 0; i < 4; i++) begin
			we[{word_base, 2'(i)}] = lane_en[i] & wr_edge;
			wb[{word_base, 2'(i)}] = lane_data[8 * i +: 8];
		end
		for (int i = 0; i < 4; i++) begin
			rword[8 * i +: 8] = rbyte[{word_base, 2'(i)}];
		end
	end

	// ==========================================
	// strobes and read command
	assign rd_edge = r_reg.rd_s3 & ~r_reg.rd_s2;
	assign wr_edge = r_reg.wr_s3 & ~r_reg.wr_s2;
	assign cmd = {`BHW_LD_READ_OP, 3'h0, r_reg.ld_word};

	// ==========================================
	// next-state logic
	always_comb begin
		r_next = r_reg;
		// two-stage synchronisers on every pin input
		r_next.rd_s1 = HOST_RD_N;
		r_next.rd_s2 = r_reg.rd_s1;
		r_next.rd_s3 = r_reg.rd_s2;
		r_next.wr_s1 = HOST_WR_N;
		r_next.wr_s2 = r_reg.wr_s1;
		r_next.wr_s3 = r_reg.wr_s2;
		r_next.addr_s1 = HOST_ADDR;
		r_next.addr_s2 = r_reg.addr_s1;
		r_next.be_s1 = BYTE_LANE_ENABLES_N;
		r_next.be_s2 = r_reg.be_s1;
		r_next.din_s1 = HOST_DATA_IN;
		r_next.din_s2 = r_reg.din_s1;
		r_next.b32_s1 = BUS_IS_32BIT;
		r_next.b32_s2 = r_reg.b32_s1;
		r_next.do_s1 = EE_DO;
		r_next.do_s2 = r_reg.do_s1;
		r_next.strap_s1 = SERIAL_MEMORY_PRESENT_STRAP;
		r_next.strap_s2 = r_reg.strap_s1;
		r_next.ext_rd = 1'b0;
		r_next.ext_wr = 1'b0;

		// local register writes, byte by byte
		r_next.base_addr = upd(r_reg.base_addr, `BHW_OFF_REG0, we, wb);
		r_next.wmark = upd(r_reg.wmark, `BHW_OFF_REG4, we, wb);
		r_next.fault = upd(r_reg.fault, `BHW_OFF_REG6, we, wb);
		r_next.burst = upd(r_reg.burst, `BHW_OFF_REG8, we, wb);
		r_next.mac_lo = upd(r_reg.mac_lo, `BHW_OFF_REG0, we, wb);
		r_next.mac_mid = upd(r_reg.mac_mid, `BHW_OFF_REG2, we, wb);
		r_next.mac_hi = upd(r_reg.mac_hi, `BHW_OFF_REG4, we, wb);
		r_next.bus_ctl = upd(r_reg.bus_ctl, `BHW_OFF_REG0, we, wb);
		r_next.bist = upd(r_reg.bist, `BHW_OFF_REG4, we, wb);
		r_next.soft_rst = upd(r_reg.soft_rst, `BHW_OFF_REG6, we, wb);
		r_next.bus_cfg = upd(r_reg.bus_cfg, `BHW_OFF_REG8, we, wb);
		// keep only the writes that hit the active bank
		if (r_reg.bank_sel != `BHW_BANK0) begin
			r_next.base_addr = r_reg.base_addr;
			r_next.wmark = r_reg.wmark;
			r_next.fault = r_reg.fault;
			r_next.burst = r_reg.burst;
		end
		if (r_reg.bank_sel != `BHW_BANK2) begin
			r_next.mac_lo = r_reg.mac_lo;
			r_next.mac_mid = r_reg.mac_mid;
			r_next.mac_hi = r_reg.mac_hi;
		end
		if (r_reg.bank_sel != `BHW_BANK3) begin
			r_next.bus_ctl = r_reg.bus_ctl;
			r_next.bist = r_reg.bist;
			r_next.soft_rst = r_reg.soft_rst;
			r_next.bus_cfg = r_reg.bus_cfg;
		end
		// the selector takes its write in any bank
		r_next.bank_sel = upd(r_reg.bank_sel, `BHW_OFF_BANK_SEL, we, wb);

		// upper banks go to the packet and switch logic; the selector word stays here
		if ((rd_edge | wr_edge) & ext_sel) begin
			r_next.ext_bank = r_reg.bank_sel;
			r_next.ext_word = word_base;
			r_next.ext_lanes = (word_base == 2'h3) ? (lane_en & 4'h3) : lane_en;
			r_next.ext_wdata = lane_data;
			r_next.ext_rd = rd_edge & ((word_base != 2'h3) | lane_en[1] | lane_en[0]);
			r_next.ext_wr = wr_edge & ((word_base != 2'h3) | lane_en[1] | lane_en[0]);
		end

		// read data: local now, upper banks when their answer comes back
		if (rd_edge) begin
			r_next.dout = rword;
		end
		if (r_reg.ext_rd) begin
			r_next.dout[15:0] = EXT_RDATA[15:0];
			if (r_reg.ext_word != 2'h3) begin
				r_next.dout[31:16] = EXT_RDATA[31:16];
			end
		end

		// serial memory fetch after reset
		r_next.ld_tick = r_reg.ld_tick + 8'h01;
		if (r_reg.ld_tick == 8'(`BHW_SK_HALF_CYC - 1)) begin
			r_next.ld_tick = 8'h00;
			unique case (r_reg.ld_state)
				LD_START: begin
					// strap is settled through its synchroniser by now
					if (r_reg.strap_s2) begin
						r_next.ld_state = LD_SHIFT;
						r_next.cs = 1'b1;
						r_next.di = cmd[8];
						r_next.ld_bit = 5'h00;
					end else begin
						r_next.ld_state = LD_DONE;
					end
				end
				LD_SHIFT: begin
					if (!r_reg.sk) begin
						// rising shift clock: memory data sampled after the command
						r_next.sk = 1'b1;
						if (r_reg.ld_bit >= `BHW_LD_CMD_BITS) begin
							r_next.ld_shift = {r_reg.ld_shift[14:0], r_reg.do_s2};
						end
					end else begin
						// falling shift clock: next command bit out
						r_next.sk = 1'b0;
						r_next.ld_bit = r_reg.ld_bit + 5'h01;
						r_next.di = (r_reg.ld_bit < 5'h08) ? cmd[4'h7 - 4'(r_reg.ld_bit)] : 1'b0;
						if (r_reg.ld_bit == `BHW_LD_LAST_BIT) begin
							r_next.cs = 1'b0;
							r_next.ld_state = LD_GAP;
						end
					end
				end
				LD_GAP: begin
					// place the word, then start the next one or finish
					unique case (r_reg.ld_word)
						`BHW_EE_BASE: r_next.base_addr = r_reg.ld_shift;
						`BHW_EE_MAC_LO: r_next.mac_lo = r_reg.ld_shift;
						`BHW_EE_MAC_MID: r_next.mac_mid = r_reg.ld_shift;
						`BHW_EE_MAC_HI: r_next.mac_hi = r_reg.ld_shift;
						`BHW_EE_CONFIG: r_next.bus_cfg = r_reg.ld_shift;
						default: begin
							// reserved words are fetched and dropped
						end
					endcase
					if (r_reg.ld_word == `BHW_LD_LAST_WORD) begin
						r_next.ld_state = LD_DONE;
					end else begin
						r_next.ld_word = r_reg.ld_word + 3'h1;
						r_next.ld_state = LD_SHIFT;
						r_next.cs = 1'b1;
						r_next.di = 1'b1;
						r_next.ld_bit = 5'h00;
					end
				end
				LD_DONE: begin
					// idle for good
				end
			endcase
		end
	end

	// ==========================================
	// state register
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			r_reg <= '0;
			r_reg.rd_s1 <= 1'b1;
			r_reg.rd_s2 <= 1'b1;
			r_reg.rd_s3 <= 1'b1;
			r_reg.wr_s1 <= 1'b1;
			r_reg.wr_s2 <= 1'b1;
			r_reg.wr_s3 <= 1'b1;
			r_reg.be_s1 <= 4'hF;
			r_reg.be_s2 <= 4'hF;
			r_reg.bank_sel <= `BHW_RST_BANK;
			r_reg.bus_cfg <= `BHW_RST_REG;
			r_reg.ld_state <= LD_START;
		end else begin
			r_reg <= r_next;
		end
	end

	// ==========================================
	// outputs
	assign HOST_DATA_OUT = r_reg.dout;
	assign HOST_DATA_OE = ~r_reg.rd_s2;
	assign EE_CS = r_reg.cs;
	assign EE_SK = r_reg.sk;
	assign EE_DI = r_reg.di;
	assign EXT_RD = r_reg.ext_rd;
	assign EXT_WR = r_reg.ext_wr;
	assign EXT_BANK = r_reg.ext_bank;
	assign EXT_WORD = r_reg.ext_word;
	assign EXT_LANES = r_reg.ext_lanes;
	assign EXT_WDATA = r_reg.ext_wdata;
	assign HOST_BUS_WIDTH_SELECT = r_reg.bus_cfg[`BHW_CFG_WIDTH_BIT];
	assign LOADED_CONFIGURATION_WORD = r_reg.bus_cfg;
	assign CHIP_SOFT_RESET = r_reg.soft_rst;
	assign LOAD_DONE = r_reg.ld_state == LD_DONE;

endmodule // bhw_window
`default_nettype wire

// ---- inc/bhw_defs.svh ----
// constants of the banked host register window
`ifndef BHW_DEFS_SVH
`define BHW_DEFS_SVH

// ==========================================
// offsets inside the sixteen-byte window
`define BHW_OFF_REG0 4'h0
`define BHW_OFF_REG2 4'h2
`define BHW_OFF_REG4 4'h4
`define BHW_OFF_REG6 4'h6
`define BHW_OFF_REG8 4'h8
`define BHW_OFF_BANK_SEL 4'hE
`define BHW_OFF_BANK_SEL_HI 4'hF

// ==========================================
// bank numbers
`define BHW_BANK0 16'h0000
`define BHW_BANK2 16'h0002
`define BHW_BANK3 16'h0003
`define BHW_BANK_EXT_FIRST 16'h0010

// ==========================================
// reset values
`define BHW_RST_REG 16'h0000
`define BHW_RST_BANK 16'h0000

// ==========================================
// serial memory fetch
`define BHW_CLK_PERIOD_NS 10
`define BHW_SK_HALF_NS 1000
`define BHW_SK_HALF_CYC ((`BHW_SK_HALF_NS + `BHW_CLK_PERIOD_NS - 1) / `BHW_CLK_PERIOD_NS)
`define BHW_LD_LAST_WORD 3'h6
`define BHW_LD_READ_OP 3'h6
`define BHW_LD_CMD_BITS 5'h09
`define BHW_LD_LAST_BIT 5'h18
`define BHW_EE_BASE 3'h0
`define BHW_EE_MAC_LO 3'h1
`define BHW_EE_MAC_MID 3'h2
`define BHW_EE_MAC_HI 3'h3
`define BHW_EE_CONFIG 3'h6
`define BHW_CFG_WIDTH_BIT 0

`endif

// ---- inc/bhw_pkg.sv ----
// types of the banked host register window
package bhw_pkg;

	// serial memory fetch states
	typedef enum logic [2:0] {LD_START, LD_SHIFT, LD_GAP, LD_DONE} bhw_ld_state_t;

	// complete state of the window
	typedef struct packed {
		logic rd_s1, rd_s2, rd_s3;
		logic wr_s1, wr_s2, wr_s3;
		logic [3:0] addr_s1, addr_s2;
		logic [3:0] be_s1, be_s2;
		logic [31:0] din_s1, din_s2;
		logic b32_s1, b32_s2;
		logic do_s1, do_s2;
		logic strap_s1, strap_s2;
		logic [15:0] base_addr, mac_lo, mac_mid, mac_hi;
		logic [15:0] wmark, fault, burst;
		logic [15:0] bus_ctl, bist, soft_rst, bus_cfg, bank_sel;
		logic [31:0] dout;
		logic ext_rd, ext_wr;
		logic [15:0] ext_bank;
		logic [1:0] ext_word;
		logic [3:0] ext_lanes;
		logic [31:0] ext_wdata;
		bhw_ld_state_t ld_state;
		logic [7:0] ld_tick;
		logic [4:0] ld_bit;
		logic [2:0] ld_word;
		logic [15:0] ld_shift;
		logic sk, cs, di;
	} bhw_state_t;

endpackage

// ---- bench/bhw_serial_mem.sv ----
// serial memory model answering the window's start-up fetch
`timescale 1ns/1ps
`default_nettype none
module bhw_serial_mem #(
	parameter logic [111:0] IMG = '0 // words 6..0 of the memory
) (
	input wire logic EE_CS, // chip select from the window
	input wire logic EE_SK, // shift clock from the window
	input wire logic EE_DI, // command bits from the window
	output logic EE_DO // data bits to the window
);
	int n; // bit times taken in this frame
	logic [8:0] cmd; // start bit, opcode and address
	logic [15:0] word; // word being shifted out
	initial begin
		n = 0;
		cmd = 9'h000;
		EE_DO = 1'b0;
	end
	// take one command bit on each of the first nine rising shift edges
	always @(posedge EE_SK) if (EE_CS) begin
		if (n < 9) cmd = {cmd[7:0], EE_DI};
		n = n + 1;
	end
	// next data bit on the falling edge, msb first; a bad command reads zero
	always @(negedge EE_SK) if (EE_CS && n >= 9 && n <= 24) begin
		word = (cmd[8:3] == 6'h30) ? IMG[16*cmd[2:0] +: 16] : 16'h0000;
		EE_DO = word[24-n];
	end
	// deselected: new frame, line shows the inverse of the last bit
	always @(negedge EE_CS) begin
		n = 0;
		EE_DO = ~EE_DO;
	end
endmodule // bhw_serial_mem
`default_nettype wire

// ---- bench/bhw_window_asserts.sv ----
// timing checks on the ports of the host register window
`timescale 1ns/1ps
`default_nettype none
module bhw_window_asserts (
	input wire logic CLK, // core clock
	input wire logic NRST, // reset, active low
	input wire logic [3:0] BYTE_LANE_ENABLES_N, // lane enables
	input wire logic HOST_RD_N, // read strobe
	input wire logic HOST_WR_N, // write strobe
	input wire logic HOST_DATA_OE, // data drive enable
	input wire logic EXT_RD, // upper bank read pulse
	input wire logic EXT_WR, // upper bank write pulse
	input wire logic [15:0] EXT_BANK, // forwarded bank
	input wire logic [1:0] EXT_WORD, // forwarded word
	input wire logic [3:0] EXT_LANES, // forwarded lanes
	input wire logic HOST_BUS_WIDTH_SELECT, // bus width
	input wire logic [15:0] LOADED_CONFIGURATION_WORD, // config word
	input wire logic EE_CS, // memory select
	input wire logic LOAD_DONE // fetch finished
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);
	// ==========================================
	// host bus
	oe_on_read_a: assert property ($fell(HOST_RD_N) |-> ##[1:4] HOST_DATA_OE)
		else $error("data drive missing after read strobe");
	oe_off_idle_a: assert property (HOST_RD_N [*5] |-> !HOST_DATA_OE)
		else $error("data driven without read strobe");
	ext_rd_pulse_a: assert property (EXT_RD |=> !EXT_RD)
		else $error("upper read pulse too long");
	ext_wr_pulse_a: assert property (EXT_WR |=> !EXT_WR)
		else $error("upper write pulse too long");
	ext_rd_cause_a: assert property ($rose(EXT_RD) |-> !HOST_RD_N && !$past(HOST_RD_N, 2))
		else $error("upper read without host read");
	ext_upper_bank_a: assert property ((EXT_RD || EXT_WR) |-> EXT_BANK >= 16'h0010)
		else $error("low bank forwarded");
	sel_masked_a: assert property ((EXT_WR && EXT_WORD == 2'h3) |-> EXT_LANES[3:2] == 2'h0)
		else $error("selector lanes forwarded");
	ext_lanes_a: assert property ((EXT_WR && EXT_WORD != 2'h3) |->
		EXT_LANES == ~$past(BYTE_LANE_ENABLES_N, 3))
		else $error("forwarded lanes differ from enables");
	// width may only move by a host write or by the start-up fetch
	width_cfg_a: assert property ($changed(HOST_BUS_WIDTH_SELECT) |->
		!$past(LOAD_DONE) || !$past(HOST_WR_N))
		else $error("width select changed without write or fetch");
	fetch_quiet_a: assert property (LOAD_DONE |=> LOAD_DONE && !EE_CS)
		else $error("memory active after fetch");
endmodule // bhw_window_asserts
bind bhw_window bhw_window_asserts u_chk (.CLK, .NRST, .BYTE_LANE_ENABLES_N, .HOST_RD_N, .HOST_WR_N,
	.HOST_DATA_OE, .EXT_RD, .EXT_WR, .EXT_BANK, .EXT_WORD, .EXT_LANES,
	.HOST_BUS_WIDTH_SELECT, .LOADED_CONFIGURATION_WORD, .EE_CS, .LOAD_DONE);
`default_nettype wire

// ---- bench/bhw_window_tb.sv ----
// self-checking testbench of the host register window
`timescale 1ns/1ps
`default_nettype none
module bhw_window_tb
	import bhw_pkg::*;
;
	localparam logic [111:0] IMG = {16'h0001, 16'h5A5A, 16'hA5A5, 16'h6655,
		16'h4433, 16'h2211, 16'h0300}; // memory words 6..0
	logic CLK, NRST, HOST_RD_N, HOST_WR_N, HOST_DATA_OE, EE_CS, EE_SK, EE_DI, EE_DO;
	logic EXT_RD, EXT_WR, HOST_BUS_WIDTH_SELECT, LOAD_DONE;
	logic BUS_IS_32BIT, SERIAL_MEMORY_PRESENT_STRAP;
	logic [3:0] HOST_ADDR, BYTE_LANE_ENABLES_N, EXT_LANES;
	logic [31:0] HOST_DATA_IN, HOST_DATA_OUT, EXT_RDATA, EXT_WDATA;
	logic [15:0] EXT_BANK, LOADED_CONFIGURATION_WORD, CHIP_SOFT_RESET;
	logic [1:0] EXT_WORD;
	int fail_count = 0, compares = 0, ext_reads = 0, ext_writes = 0;
	bhw_window uut (.CLK, .NRST, .HOST_ADDR, .BYTE_LANE_ENABLES_N, .HOST_RD_N, .HOST_WR_N,
		.HOST_DATA_IN, .HOST_DATA_OUT, .HOST_DATA_OE, .BUS_IS_32BIT,
		.SERIAL_MEMORY_PRESENT_STRAP, .EE_CS, .EE_SK, .EE_DI, .EE_DO, .EXT_RD,
		.EXT_WR, .EXT_BANK, .EXT_WORD, .EXT_LANES, .EXT_WDATA, .EXT_RDATA,
		.HOST_BUS_WIDTH_SELECT, .LOADED_CONFIGURATION_WORD, .CHIP_SOFT_RESET, .LOAD_DONE);
	bhw_serial_mem #(.IMG(IMG)) mem (.EE_CS, .EE_SK, .EE_DI, .EE_DO);
	// ==========================================
	// clock and pulse counting
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	always @(posedge CLK) if (EXT_RD === 1'b1) ext_reads++;
	always @(posedge CLK) if (EXT_WR === 1'b1) ext_writes++;
	// ==========================================
	// shared tasks
	task automatic chk(input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// one host access: pins set, strobe low 7 edges, then held 4 edges
	task automatic acc(input logic w, input logic [3:0] a, b, input logic [31:0] d,
		output logic [31:0] q);
		HOST_ADDR = a;
		BYTE_LANE_ENABLES_N = b;
		HOST_DATA_IN = d;
		repeat (3) @(posedge CLK);
		#1;
		if (w) HOST_WR_N = 1'b0;
		else HOST_RD_N = 1'b0;
		repeat (7) @(posedge CLK);
		#1;
		q = HOST_DATA_OUT;
		if (!w) chk({31'h0, HOST_DATA_OE}, 32'h1);
		HOST_WR_N = 1'b1;
		HOST_RD_N = 1'b1;
		repeat (4) @(posedge CLK);
		#1;
		chk({31'h0, HOST_DATA_OE}, 32'h0);
	endtask
	task automatic wr(input logic [3:0] a, b, input logic [31:0] d);
		logic [31:0] q;
		acc(1'b1, a, b, d, q);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		acc(1'b0, a, 4'h0, 32'h0, q);
		chk(q, e);
	endtask
	task automatic sel(input logic [15:0] n);
		wr(4'hC, 4'h3, {n, 16'h0000}); // selector on lanes 2 and 3
	endtask
	// ==========================================
	// scenarios
	task automatic t_fetch;
		sel(16'h0000);
		rd(4'h0, {16'h0000, IMG[15:0]});
		rd(4'h4, 32'h0000_0000);
		sel(16'h0002);
		rd(4'h0, IMG[47:16]);
		rd(4'h4, {16'h0000, IMG[63:48]});
		sel(16'h0003);
		rd(4'h8, {16'h0000, IMG[111:96]});
		chk({16'h0000, LOADED_CONFIGURATION_WORD}, {16'h0000, IMG[111:96]});
		chk({31'h0, HOST_BUS_WIDTH_SELECT}, 32'h1);
		$display("test fetch done");
	endtask
	task automatic t_lanes;
		sel(16'h0003);
		wr(4'h4, 4'h0, 32'h89AB_CDEF);
		rd(4'h4, 32'h89AB_CDEF);
		wr(4'h4, 4'hD, 32'h0000_5500);
		wr(4'h4, 4'h7, 32'h7700_0000);
		rd(4'h4, 32'h77AB_55EF);
		chk({16'h0000, CHIP_SOFT_RESET}, 32'h77AB);
		wr(4'h4, 4'h3, 32'h4321_0000);
		rd(4'h4, 32'h4321_55EF);
		$display("test lanes done");
	endtask
	task automatic t_resv;
		logic [15:0] b [4] = '{16'h0001, 16'h0004, 16'h0008, 16'h000F};
		foreach (b[i]) begin
			sel(b[i]);
			wr(4'h0, 4'h0, 32'hFFFF_FFFF);
			rd(4'h0, 32'h0000_0000);
			rd(4'hC, {b[i], 16'h0000});
		end
		sel(16'h0000);
		rd(4'h0, {16'h0000, IMG[15:0]});
		$display("test reserved done");
	endtask
	task automatic t_ext;
		int n;
		sel(16'h0010);
		EXT_RDATA = 32'hDEAD_BEEF;
		n = ext_reads;
		rd(4'h0, 32'hDEAD_BEEF);
		chk(32'(ext_reads - n), 32'h1);
		n = ext_writes;
		wr(4'h8, 4'h0, 32'h1122_3344);
		chk(32'(ext_writes - n), 32'h1);
		chk({EXT_BANK, 14'h0, EXT_WORD}, 32'h0010_0002);
		chk({28'h0, EXT_LANES}, 32'hF);
		chk(EXT_WDATA, 32'h1122_3344);
		wr(4'hC, 4'h0, 32'h0000_ABCD);
		rd(4'hC, 32'h0000_0000);
		$display("test upper banks done");
	endtask
	task automatic t_width;
		sel(16'h0003);
		wr(4'h8, 4'hC, 32'h0000_0000);
		chk({31'h0, HOST_BUS_WIDTH_SELECT}, 32'h0);
		chk({16'h0000, LOADED_CONFIGURATION_WORD}, 32'h0000);
		wr(4'h8, 4'hC, 32'h0000_0001);
		chk({31'h0, HOST_BUS_WIDTH_SELECT}, 32'h1);
		chk({16'h0000, LOADED_CONFIGURATION_WORD}, 32'h0001);
		$display("test width done");
	endtask
	// 16-bit then 8-bit variant on the same bank map, bank 3 still active
	task automatic t_b16;
		BUS_IS_32BIT = 1'b0;
		wr(4'h6, 4'hC, 32'h0000_1357);
		chk({16'h0000, CHIP_SOFT_RESET}, 32'h1357);
		rd(4'h4, 32'h1357_55EF);
		wr(4'h8, 4'hC, 32'h0000_0000);
		wr(4'h7, 4'hF, 32'h0000_00A5);
		chk({16'h0000, CHIP_SOFT_RESET}, 32'hA557);
		rd(4'h7, 32'hA557_55EF);
		wr(4'h8, 4'hF, 32'h0000_0001);
		chk({16'h0000, LOADED_CONFIGURATION_WORD}, 32'h0001);
		BUS_IS_32BIT = 1'b1;
		$display("test narrow buses done");
	endtask
	// second reset with no serial memory: fetch skipped after one half period
	task automatic t_skip;
		SERIAL_MEMORY_PRESENT_STRAP = 1'b0;
		NRST = 1'b0;
		repeat (5) @(posedge CLK);
		#1 NRST = 1'b1;
		repeat (50) @(posedge CLK);
		#1;
		chk({31'h0, LOAD_DONE}, 32'h0);
		repeat (60) @(posedge CLK);
		#1;
		chk({31'h0, LOAD_DONE}, 32'h1);
		chk({31'h0, EE_CS}, 32'h0);
		rd(4'h0, 32'h0000_0000);
		chk({16'h0000, LOADED_CONFIGURATION_WORD}, 32'h0000);
		$display("test no memory done");
	endtask
	task automatic final_report;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// ==========================================
	// main sequence and watchdog
	initial begin
		NRST = 1'b0;
		HOST_RD_N = 1'b1;
		HOST_WR_N = 1'b1;
		HOST_ADDR = 4'h0;
		BYTE_LANE_ENABLES_N = 4'hF;
		HOST_DATA_IN = 32'h0;
		EXT_RDATA = 32'h0;
		BUS_IS_32BIT = 1'b1;
		SERIAL_MEMORY_PRESENT_STRAP = 1'b1;
		repeat (5) @(posedge CLK);
		#1 NRST = 1'b1;
		for (int i = 0; i < 50000 && LOAD_DONE !== 1'b1; i++) begin
			@(posedge CLK);
			#1;
		end
		chk({31'h0, LOAD_DONE}, 32'h1);
		t_fetch;
		t_lanes;
		t_resv;
		t_ext;
		t_width;
		t_b16;
		t_skip;
		final_report;
	end
	initial begin
		repeat (80000) @(posedge CLK);
		fail_count++;
		final_report;
	end
endmodule // bhw_window_tb
`default_nettype wire
